// *** src/lcr_pkg.sv ***
// Package: register map, field layout and reset values of the laser channel config bank
package lcr_pkg;

    localparam int NUM_REGS = 7;

    // Register indices, in the order of the tables below
    localparam int IDX_CHAN1_PULSE_COMP  = 0;
    localparam int IDX_CHAN2_MODE        = 1;
    localparam int IDX_CHAN2_OVERCURRENT = 2;
    localparam int IDX_CHAN2_RESISTOR    = 3;
    localparam int IDX_CHAN2_PULSE_SAT   = 4;
    localparam int IDX_LASER_TYPE        = 5;
    localparam int IDX_REF_SCALE         = 6;

    // Byte offsets on the register port
    localparam logic [7:0] CHAN1_PULSE_COMP_CFG_ADDR        = 8'h13;
    localparam logic [7:0] CHAN2_MODE_CFG_ADDR              = 8'h15;
    localparam logic [7:0] CHAN2_OVERCURRENT_THRESHOLD_ADDR = 8'h16;
    localparam logic [7:0] CHAN2_MONITOR_RESISTOR_ADDR      = 8'h17;
    localparam logic [7:0] CHAN2_PULSE_COMP_SAT_CFG_ADDR    = 8'h18;
    localparam logic [7:0] LASER_TYPE_SELECT_ADDR           = 8'h1a;
    localparam logic [7:0] REFERENCE_SCALE_SELECT_ADDR      = 8'h1e;

    // Reset values of the implemented bits
    localparam logic [7:0] CHAN1_PULSE_COMP_CFG_RST        = 8'h00;
    localparam logic [7:0] CHAN2_MODE_CFG_RST              = 8'h08;
    localparam logic [7:0] CHAN2_OVERCURRENT_THRESHOLD_RST = 8'hff;
    localparam logic [7:0] CHAN2_MONITOR_RESISTOR_RST      = 8'hff;
    localparam logic [7:0] CHAN2_PULSE_COMP_SAT_CFG_RST    = 8'h30;
    localparam logic [7:0] LASER_TYPE_SELECT_RST           = 8'h00;
    localparam logic [7:0] REFERENCE_SCALE_SELECT_RST      = 8'h00;

    // Bits held by this bank; the others belong to neighbouring blocks and read zero
    localparam logic [7:0] CHAN1_PULSE_COMP_CFG_MASK        = 8'h80;
    localparam logic [7:0] CHAN2_MODE_CFG_MASK              = 8'hff;
    localparam logic [7:0] CHAN2_OVERCURRENT_THRESHOLD_MASK = 8'hff;
    localparam logic [7:0] CHAN2_MONITOR_RESISTOR_MASK      = 8'hff;
    localparam logic [7:0] CHAN2_PULSE_COMP_SAT_CFG_MASK    = 8'hfc;
    localparam logic [7:0] LASER_TYPE_SELECT_MASK           = 8'he8;
    localparam logic [7:0] REFERENCE_SCALE_SELECT_MASK      = 8'h88;

    // Tables indexed by the register index (entry 0 in the low byte)
    localparam logic [NUM_REGS-1:0][7:0] REG_ADDR = {
        REFERENCE_SCALE_SELECT_ADDR, LASER_TYPE_SELECT_ADDR, CHAN2_PULSE_COMP_SAT_CFG_ADDR,
        CHAN2_MONITOR_RESISTOR_ADDR, CHAN2_OVERCURRENT_THRESHOLD_ADDR, CHAN2_MODE_CFG_ADDR,
        CHAN1_PULSE_COMP_CFG_ADDR};
    localparam logic [NUM_REGS-1:0][7:0] REG_RST = {
        REFERENCE_SCALE_SELECT_RST, LASER_TYPE_SELECT_RST, CHAN2_PULSE_COMP_SAT_CFG_RST,
        CHAN2_MONITOR_RESISTOR_RST, CHAN2_OVERCURRENT_THRESHOLD_RST, CHAN2_MODE_CFG_RST,
        CHAN1_PULSE_COMP_CFG_RST};
    localparam logic [NUM_REGS-1:0][7:0] REG_MASK = {
        REFERENCE_SCALE_SELECT_MASK, LASER_TYPE_SELECT_MASK, CHAN2_PULSE_COMP_SAT_CFG_MASK,
        CHAN2_MONITOR_RESISTOR_MASK, CHAN2_OVERCURRENT_THRESHOLD_MASK, CHAN2_MODE_CFG_MASK,
        CHAN1_PULSE_COMP_CFG_MASK};

    // Field positions
    localparam int PULSED_ENABLE_BIT    = 7;
    localparam int CURRENT_REG_BIT      = 0;
    localparam int INTEGRATOR_CAP_BIT   = 1;
    localparam int RESISTOR_OFF_BIT     = 2;
    localparam int PIN_BLOCK_BIT        = 3;
    localparam int CONV_SRC_LSB         = 5;
    localparam int COMPENSATION_LSB     = 4;
    localparam int SAT_MARGIN_LSB       = 2;
    localparam int CHAN1_TYPE_BIT       = 3;
    localparam int CHAN2_TYPE_BIT       = 7;
    localparam int CHAN2_CUR_MEAS_BIT   = 5;
    localparam int CHAN2_FORCE_SENSE_BIT = 6;
    localparam int CHAN1_SCALE_BIT      = 3;
    localparam int CHAN2_SCALE_BIT      = 7;

    // Converter source codes and the zero overcurrent level
    localparam logic [2:0] CONV_SRC_MONITOR      = 3'h4;
    localparam logic [2:0] CONV_SRC_CORE_SUPPLY  = 3'h5;
    localparam logic [2:0] CONV_SRC_LASER_SUPPLY = 3'h6;
    localparam logic [2:0] CONV_SRC_LASER_NODE   = 3'h7;
    localparam logic [7:0] OVERCURRENT_ZERO      = 8'h00;

    typedef enum logic [2:0] {
        ROUTE_OFF,
        ROUTE_MONITOR_PAD,
        ROUTE_RESISTOR_NODE,
        ROUTE_CURRENT_SENSOR,
        ROUTE_CORE_SUPPLY,
        ROUTE_LASER_SUPPLY,
        ROUTE_LASER_NODE
    } lcr_route_e;

endpackage

// *** src/lcr_field_reg.sv ***
// Module: one byte-wide configuration register with per-bit implement mask
`timescale 1ns/10ps
module lcr_field_reg #(
    parameter logic [7:0] RESET = 8'h00,
    parameter logic [7:0] MASK  = 8'hff
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // Stored value
    output logic      [7:0] value
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Unimplemented bits stay zero so they always read back as zero
    assign value_next = wr_en ? (wr_data & MASK) : value_reg;
    assign value      = value_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RESET & MASK;
        end else begin
            value_reg <= value_next;
        end
    end

endmodule

// *** src/lcr_regs.sv ***
// Module: configuration bank for laser channel 2 plus per-channel type, pulse and scale selects
`timescale 1ns/10ps

// How it works
// - Laser type per channel at 0x1A bits 3 and 7; 0 P-type, 1 M-type.
// - Pulsed enable at bit 7 of 0x13 and 0x18; reset off.
// - Reference scale at 0x1E bits 3 and 7; 0 logarithmic, 1 linear.
// - 0x15 bit 0 picks power (0) or current (1) regulation for channel 2.
// - 0x15 bit 1 connects the external integrator capacitor when 1.
// - 0x15 bit 2 set turns the internal monitor resistor off.
// - 0x15 bit 3 blocks the enable pin, reset 1 meaning blocked.
// - 0x15 bits 7:5 pick converter source; 0xx off, 100..111 sources.
// - 0x16 overcurrent level, reset 0xFF; zero disables protection in current mode.
// - 0x17 monitor resistor code, logarithmic, 0x00 min to 0xFF max.
// - 0x18 bits 6:4 compensation strength, reset 011.
// - 0x18 bits 3:2 saturation margin; alarm raised by comparator beyond margin.
// - Code 100 without current measure: force/sense bit picks pad or resistor node.
// - Current-measure bit makes code 100 route the current sensor.
module lcr_regs (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                arst_n,
    // Register port
    input  wire logic                reg_wr_en,
    input  wire logic                reg_rd_en,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wr_data,
    output logic      [7:0]          reg_rd_data,
    output logic                     reg_rd_valid,
    // Channel pins and comparator
    input  wire logic                chan2_enable_pin,
    input  wire logic                chan2_saturation_comp,
    output logic                     chan2_channel_enable,
    output logic                     chan2_saturation_alarm,
    // Per-channel selections
    output logic                     chan1_laser_type,
    output logic                     chan2_laser_type,
    output logic                     chan1_pulsed_enable,
    output logic                     chan2_pulsed_enable,
    output logic                     chan1_ref_scale,
    output logic                     chan2_ref_scale,
    // Channel 2 analog controls
    output logic                     chan2_current_regulation,
    output logic                     chan2_integrator_cap_connect,
    output logic                     chan2_internal_resistor_off,
    output logic                     chan2_pin_enable_block,
    output logic      [2:0]          chan2_converter_source,
    output logic                     chan2_force_sense_select,
    output logic                     chan2_current_measure,
    output lcr_pkg::lcr_route_e      chan2_adc_route,
    output logic      [7:0]          chan2_overcurrent_level,
    output logic                     chan2_overcurrent_protect_off,
    output logic      [7:0]          chan2_resistor_code,
    output logic      [2:0]          chan2_compensation,
    output logic      [1:0]          chan2_saturation_margin
);

    logic                                    rst_sync1_reg;
    logic                                    rst_n_reg;
    logic [lcr_pkg::NUM_REGS-1:0]            hit;
    logic [lcr_pkg::NUM_REGS-1:0][7:0]       regval;
    logic [lcr_pkg::NUM_REGS-1:0][7:0]       rd_terms;
    logic [7:0]                              rd_mux;
    logic [7:0]                              rd_data_reg;
    logic                                    rd_valid_reg;
    logic [7:0]                              mode_cfg;
    logic [7:0]                              pulse_sat_cfg;
    logic [7:0]                              type_cfg;
    logic [7:0]                              scale_cfg;
    lcr_pkg::lcr_route_e                     route_next;
    lcr_pkg::lcr_route_e                     route_reg;
    logic                                    chan_enable_reg;
    logic                                    sat_alarm_reg;
    logic                                    protect_off_reg;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync1_reg <= 1'b0;
            rst_n_reg     <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n_reg     <= rst_sync1_reg;
        end
    end

    // One storage cell per mapped offset, reset and mask from the package tables
    genvar gi;
    generate
        for (gi = 0; gi < lcr_pkg::NUM_REGS; gi = gi + 1) begin : g_reg
            assign hit[gi] = (reg_addr == lcr_pkg::REG_ADDR[gi]);
            assign rd_terms[gi] = hit[gi] ? regval[gi] : 8'h00;
            lcr_field_reg #(
                .RESET (lcr_pkg::REG_RST[gi]),
                .MASK  (lcr_pkg::REG_MASK[gi])
            ) u_cell (
                .clk     (mclk),
                .rst_n   (rst_n_reg),
                .wr_en   (reg_wr_en & hit[gi]),
                .wr_data (reg_wr_data),
                .value   (regval[gi])
            );
        end
    endgenerate

    // Offsets are unique so an OR of the gated terms is the read mux; unmapped reads 0x00
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < lcr_pkg::NUM_REGS; i++) begin
            rd_mux = rd_mux | rd_terms[i];
        end
    end

    always_ff @(posedge mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= reg_rd_en;
            if (reg_rd_en) begin
                rd_data_reg <= rd_mux;
            end
        end
    end

    assign reg_rd_data  = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    // Field views
    assign mode_cfg      = regval[lcr_pkg::IDX_CHAN2_MODE];
    assign pulse_sat_cfg = regval[lcr_pkg::IDX_CHAN2_PULSE_SAT];
    assign type_cfg      = regval[lcr_pkg::IDX_LASER_TYPE];
    assign scale_cfg     = regval[lcr_pkg::IDX_REF_SCALE];

    assign chan1_laser_type    = type_cfg[lcr_pkg::CHAN1_TYPE_BIT];
    assign chan2_laser_type    = type_cfg[lcr_pkg::CHAN2_TYPE_BIT];
    assign chan1_pulsed_enable =
        regval[lcr_pkg::IDX_CHAN1_PULSE_COMP][lcr_pkg::PULSED_ENABLE_BIT];
    assign chan2_pulsed_enable = pulse_sat_cfg[lcr_pkg::PULSED_ENABLE_BIT];
    assign chan1_ref_scale     = scale_cfg[lcr_pkg::CHAN1_SCALE_BIT];
    assign chan2_ref_scale     = scale_cfg[lcr_pkg::CHAN2_SCALE_BIT];

    assign chan2_current_regulation     = mode_cfg[lcr_pkg::CURRENT_REG_BIT];
    assign chan2_integrator_cap_connect = mode_cfg[lcr_pkg::INTEGRATOR_CAP_BIT];
    assign chan2_internal_resistor_off  = mode_cfg[lcr_pkg::RESISTOR_OFF_BIT];
    assign chan2_pin_enable_block       = mode_cfg[lcr_pkg::PIN_BLOCK_BIT];
    assign chan2_converter_source       =
        mode_cfg[lcr_pkg::CONV_SRC_LSB +: 3];
    assign chan2_force_sense_select     = type_cfg[lcr_pkg::CHAN2_FORCE_SENSE_BIT];
    assign chan2_current_measure        = type_cfg[lcr_pkg::CHAN2_CUR_MEAS_BIT];

    assign chan2_overcurrent_level = regval[lcr_pkg::IDX_CHAN2_OVERCURRENT];
    assign chan2_resistor_code     = regval[lcr_pkg::IDX_CHAN2_RESISTOR];
    assign chan2_compensation      =
        pulse_sat_cfg[lcr_pkg::COMPENSATION_LSB +: 3];
    assign chan2_saturation_margin =
        pulse_sat_cfg[lcr_pkg::SAT_MARGIN_LSB +: 2];

    // Converter routing; code 100 is shared by three paths told apart by two bits
    always_comb begin
        route_next = lcr_pkg::ROUTE_OFF;
        unique casez (chan2_converter_source)
            3'b0??: route_next = lcr_pkg::ROUTE_OFF;
            lcr_pkg::CONV_SRC_MONITOR: begin
                if (chan2_current_measure) begin
                    route_next = lcr_pkg::ROUTE_CURRENT_SENSOR;
                end else if (chan2_force_sense_select) begin
                    route_next = lcr_pkg::ROUTE_MONITOR_PAD;
                end else begin
                    route_next = lcr_pkg::ROUTE_RESISTOR_NODE;
                end
            end
            lcr_pkg::CONV_SRC_CORE_SUPPLY:  route_next = lcr_pkg::ROUTE_CORE_SUPPLY;
            lcr_pkg::CONV_SRC_LASER_SUPPLY: route_next = lcr_pkg::ROUTE_LASER_SUPPLY;
            lcr_pkg::CONV_SRC_LASER_NODE:   route_next = lcr_pkg::ROUTE_LASER_NODE;
        endcase
    end

    // Derived channel controls are registered, so they trail a write by one cycle
    always_ff @(posedge mclk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            route_reg       <= lcr_pkg::ROUTE_OFF;
            chan_enable_reg <= 1'b0;
            sat_alarm_reg   <= 1'b0;
            protect_off_reg <= 1'b0;
        end else begin
            route_reg       <= route_next;
            chan_enable_reg <= chan2_enable_pin & ~chan2_pin_enable_block;
            sat_alarm_reg   <= chan2_saturation_comp;
            protect_off_reg <= chan2_current_regulation &
                               (chan2_overcurrent_level == lcr_pkg::OVERCURRENT_ZERO);
        end
    end

    assign chan2_adc_route               = route_reg;
    assign chan2_channel_enable          = chan_enable_reg;
    assign chan2_saturation_alarm        = sat_alarm_reg;
    assign chan2_overcurrent_protect_off = protect_off_reg;

endmodule

// *** tb/lcr_regs_sva.sv ***
// Checker: port-level properties of the laser channel configuration bank
`timescale 1ns/10ps
module lcr_regs_sva (
    // Clock, reset and register port
    input wire logic                mclk,
    input wire logic                arst_n,
    input wire logic                reg_wr_en,
    input wire logic                reg_rd_en,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wr_data,
    input wire logic [7:0]          reg_rd_data,
    input wire logic                reg_rd_valid,
    // Pins and channel 2 controls
    input wire logic                chan2_enable_pin,
    input wire logic                chan2_saturation_comp,
    input wire logic                chan2_channel_enable,
    input wire logic                chan2_saturation_alarm,
    input wire logic                chan2_current_regulation,
    input wire logic                chan2_pin_enable_block,
    input wire logic [2:0]          chan2_converter_source,
    input wire logic                chan2_force_sense_select,
    input wire logic                chan2_current_measure,
    input wire lcr_pkg::lcr_route_e chan2_adc_route,
    input wire logic [7:0]          chan2_overcurrent_level,
    input wire logic                chan2_overcurrent_protect_off
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Independent decode so a slip in the design's table cannot hide here
    function automatic lcr_pkg::lcr_route_e route_of(logic [2:0] s, logic cm, logic fs);
        case (s)
            3'h4: route_of = cm ? lcr_pkg::ROUTE_CURRENT_SENSOR
                : (fs ? lcr_pkg::ROUTE_MONITOR_PAD : lcr_pkg::ROUTE_RESISTOR_NODE);
            3'h5: route_of = lcr_pkg::ROUTE_CORE_SUPPLY;
            3'h6: route_of = lcr_pkg::ROUTE_LASER_SUPPLY;
            3'h7: route_of = lcr_pkg::ROUTE_LASER_NODE;
            default: route_of = lcr_pkg::ROUTE_OFF;
        endcase
    endfunction

    sequence s_wr15; reg_wr_en && reg_addr == 8'h15; endsequence
    sequence s_wr16; reg_wr_en && reg_addr == 8'h16; endsequence
    sequence s_rd16; reg_rd_en && !reg_wr_en && reg_addr == 8'h16; endsequence

    property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
    property p_rd_pulse; !reg_rd_en |=> !reg_rd_valid; endproperty
    property p_mode_wr;
        s_wr15 |=> chan2_converter_source == $past(reg_wr_data[7:5])
            && chan2_current_regulation == $past(reg_wr_data[0]);
    endproperty
    property p_ovc_wr; s_wr16 |=> chan2_overcurrent_level == $past(reg_wr_data); endproperty
    property p_ovc_rd; s_rd16 |=> reg_rd_data == chan2_overcurrent_level; endproperty
    property p_pin;
        chan2_channel_enable == ($past(chan2_enable_pin) && !$past(chan2_pin_enable_block));
    endproperty
    property p_sat; chan2_saturation_alarm == $past(chan2_saturation_comp); endproperty
    property p_prot;
        chan2_overcurrent_protect_off
            == ($past(chan2_current_regulation) && $past(chan2_overcurrent_level) == 8'h00);
    endproperty
    property p_route;
        chan2_adc_route == route_of($past(chan2_converter_source),
            $past(chan2_current_measure), $past(chan2_force_sense_select));
    endproperty

    a_rd_valid: assert property (p_rd_valid) else $error("read gave no valid");
    a_rd_pulse: assert property (p_rd_pulse) else $error("stray read valid");
    a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
    a_ovc_wr: assert property (p_ovc_wr) else $error("level write lost");
    a_ovc_rd: assert property (p_ovc_rd) else $error("level readback wrong");
    a_pin: assert property (p_pin) else $error("pin gating wrong");
    a_sat: assert property (p_sat) else $error("saturation alarm wrong");
    a_prot: assert property (p_prot) else $error("protection off wrong");
    a_route: assert property (p_route) else $error("converter route wrong");
endmodule

bind lcr_regs lcr_regs_sva u_lcr_regs_sva (.mclk, .arst_n, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_valid, .chan2_enable_pin,
    .chan2_saturation_comp, .chan2_channel_enable, .chan2_saturation_alarm,
    .chan2_current_regulation, .chan2_pin_enable_block, .chan2_converter_source,
    .chan2_force_sense_select, .chan2_current_measure, .chan2_adc_route,
    .chan2_overcurrent_level, .chan2_overcurrent_protect_off);

// *** tb/test_lcr_regs.sv ***
// Testbench: self-checking bench for the laser channel configuration bank
`timescale 1ns/10ps
module test_lcr_regs;
    logic mclk, arst_n, reg_wr_en, reg_rd_en, chan2_enable_pin, chan2_saturation_comp;
    logic [7:0] reg_addr, reg_wr_data;
    int n_errors, checked;
    // Rows: address, reset value, written value, value read back
    logic [31:0] rows [8] = '{32'h13_00_ff_80, 32'h15_08_a6_a6, 32'h16_ff_00_00,
        32'h17_ff_5a_5a, 32'h18_30_ff_fc, 32'h1a_00_ff_e8, 32'h1e_00_ff_88, 32'h14_00_ab_00};
    lcr_pkg::lcr_route_e exp_route [8] = '{lcr_pkg::ROUTE_OFF, lcr_pkg::ROUTE_OFF,
        lcr_pkg::ROUTE_OFF, lcr_pkg::ROUTE_OFF, lcr_pkg::ROUTE_MONITOR_PAD,
        lcr_pkg::ROUTE_CORE_SUPPLY, lcr_pkg::ROUTE_LASER_SUPPLY, lcr_pkg::ROUTE_LASER_NODE};
    wire logic [7:0] rd_data, res_code, ovc;
    wire logic [2:0] comp, src;
    wire logic [1:0] marg;
    wire logic p1, p2, t1, t2, s1, s2, creg, cap, roff, blk, fs, cm, ch_en, alarm, prot;
    wire lcr_pkg::lcr_route_e route;
    wire logic rd_valid;
    wire logic [25:0] outs = {p1, p2, s1, s2, t1, t2, comp, marg, res_code, src, blk, roff,
        cap, creg};

    lcr_regs u_lcr_regs (.mclk(mclk), .arst_n(arst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .chan2_enable_pin(chan2_enable_pin),
        .chan2_saturation_comp(chan2_saturation_comp), .chan2_channel_enable(ch_en),
        .chan2_saturation_alarm(alarm), .chan1_laser_type(t1), .chan2_laser_type(t2),
        .chan1_pulsed_enable(p1), .chan2_pulsed_enable(p2), .chan1_ref_scale(s1),
        .chan2_ref_scale(s2), .chan2_current_regulation(creg),
        .chan2_integrator_cap_connect(cap), .chan2_internal_resistor_off(roff),
        .chan2_pin_enable_block(blk), .chan2_converter_source(src),
        .chan2_force_sense_select(fs), .chan2_current_measure(cm), .chan2_adc_route(route),
        .chan2_overcurrent_level(ovc), .chan2_overcurrent_protect_off(prot),
        .chan2_resistor_code(res_code), .chan2_compensation(comp),
        .chan2_saturation_margin(marg));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task results;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Reset is released at a falling edge; the design needs two more edges before use
    task rst;
        arst_n = 1'b0;
        tick(12);
        arst_n = 1'b1;
        tick(3);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge mclk);
        reg_wr_en = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        chk({rd_valid, rd_data}, {1'b1, exp});
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        results;
    end

    initial begin
        {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
        {chan2_enable_pin, chan2_saturation_comp} = 2'b00;
        n_errors = 0;
        checked = 0;
        rst();
        chk(outs, {6'h00, 3'h3, 2'h0, 8'hff, 3'h0, 4'h8});
        chk({route, ch_en, alarm, prot, rd_valid, rd_data}, 32'h0);
        foreach (rows[i]) begin
            rd(rows[i][31:24], rows[i][23:16]);
            wr(rows[i][31:24], rows[i][15:8]);
            rd(rows[i][31:24], rows[i][7:0]);
        end
        chk(outs, {6'h3f, 3'h7, 2'h3, 8'h5a, 3'h5, 4'h6});
        chk({fs, cm, ovc}, {2'b11, 8'h00});
        wr(8'h1a, 8'h40);
        for (int s = 0; s < 8; s++) begin
            wr(8'h15, {s[2:0], 5'h00});
            tick(1);
            chk(route, exp_route[s]);
        end
        wr(8'h15, 8'h80);
        wr(8'h1a, 8'h00);
        tick(1);
        chk(route, lcr_pkg::ROUTE_RESISTOR_NODE);
        wr(8'h1a, 8'h60);
        tick(1);
        chk(route, lcr_pkg::ROUTE_CURRENT_SENSOR);
        // Pin enable is allowed only while the block bit is clear
        wr(8'h15, 8'h00);
        chan2_enable_pin = 1'b1;
        tick(1);
        chk(ch_en, 1'b1);
        wr(8'h15, 8'h08);
        tick(1);
        chk(ch_en, 1'b0);
        chan2_enable_pin = 1'b0;
        wr(8'h15, 8'h01);
        wr(8'h16, 8'h00);
        tick(1);
        chk(prot, 1'b1);
        wr(8'h16, 8'h01);
        tick(1);
        chk(prot, 1'b0);
        wr(8'h15, 8'h00);
        tick(1);
        chk(prot, 1'b0);
        chan2_saturation_comp = 1'b1;
        tick(1);
        chk(alarm, 1'b1);
        chan2_saturation_comp = 1'b0;
        tick(1);
        chk(alarm, 1'b0);
        // Read and write to one place in one cycle must return the old byte
        @(negedge mclk);
        {reg_wr_en, reg_rd_en} = 2'b11;
        reg_addr = 8'h17;
        reg_wr_data = 8'h11;
        @(negedge mclk);
        {reg_wr_en, reg_rd_en} = 2'b00;
        chk(rd_data, 8'h5a);
        rd(8'h17, 8'h11);
        rst();
        chk(outs, {6'h00, 3'h3, 2'h0, 8'hff, 3'h0, 4'h8});
        rd(8'h16, 8'hff);
        rd(8'h15, 8'h08);
        results;
    end
endmodule
